// ---- shared/lpgc_pkg.sv ----
`default_nettype none
package lpgc_pkg;

    // register offsets on the special-function-register bus
    localparam logic [7:0] OFS_PORT_A_OPENDRAIN = 8'ha0;
    localparam logic [7:0] OFS_PORT_B_OPENDRAIN = 8'ha1;
    localparam logic [7:0] OFS_PORT_C_OPENDRAIN = 8'ha2;
    localparam logic [7:0] OFS_PORT_A_PULLUP    = 8'ha5;
    localparam logic [7:0] OFS_PORT_B_PULLUP    = 8'ha6;
    localparam logic [7:0] OFS_PORT_C_PULLUP    = 8'ha7;
    localparam logic [7:0] OFS_PORT_A_ALTSEL    = 8'haa;
    localparam logic [7:0] OFS_PORT_B_ALTSEL    = 8'hab;
    localparam logic [7:0] OFS_PORT_A           = 8'hc0;
    localparam logic [7:0] OFS_PORT_A_DIR       = 8'hc1;
    localparam logic [7:0] OFS_PORT_B           = 8'hc2;
    localparam logic [7:0] OFS_PORT_B_DIR       = 8'hc3;
    localparam logic [7:0] OFS_PORT_C           = 8'hc4;
    localparam logic [7:0] OFS_PORT_C_DIR       = 8'hc5;

    // reset value shared by every control and data register
    localparam logic [7:0] RST_VALUE = 8'h00;

    // implemented bit positions of each port
    localparam logic [7:0] PORT_A_MASK       = 8'hd2;
    localparam logic [7:0] PORT_B_MASK       = 8'h01;
    localparam logic [7:0] PORT_C_MASK       = 8'h3f;
    localparam logic [7:0] PORT_C_SMALL_MASK = 8'h0f;

    // alternate-function select field positions
    localparam int ALT_IRQ_B_BIT   = 7;
    localparam int ALT_IRQ_A_BIT   = 6;
    localparam int ALT_BUZZER_BIT  = 4;
    localparam int ALT_EVENT_BIT   = 1;
    localparam int ALT_PWM_B_BIT   = 0;
    localparam logic [7:0] PORT_A_ALTSEL_MASK = 8'hd2;
    localparam logic [7:0] PORT_B_ALTSEL_MASK = 8'h01;

    // pin input synchroniser depth and pad output latency in cycles
    localparam int SYNC_STAGES = 2;
    localparam int PAD_LATENCY = 1;

endpackage : lpgc_pkg
`default_nettype wire

// ---- design/lpgc_pad.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpgc_pad #(
    parameter int         W    = 8,
    parameter logic [7:0] IMPL = 8'hff
) (
    input  wire logic         clk_in,
    input  wire logic         reset_in,
    input  wire logic [W-1:0] data_in,
    input  wire logic [W-1:0] dir_in,
    input  wire logic [W-1:0] od_in,
    input  wire logic [W-1:0] alt_drv_in,
    input  wire logic [W-1:0] alt_val_in,
    input  wire logic [W-1:0] alt_inp_in,
    input  wire logic [W-1:0] pin_raw_in,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe_n_out,
    output logic      [W-1:0] pin_sync_out
);
    logic [W-1:0] impl;
    logic [W-1:0] drive;
    logic [W-1:0] value;
    logic [W-1:0] out_r, out_nxt;
    logic [W-1:0] oe_n_r, oe_n_nxt;
    logic [W-1:0] s1_r, s2_r;

    assign impl = IMPL[W-1:0];

    // drive decision: alt output, or gpio output not claimed by alt input
    always_comb begin
        drive    = impl & ((dir_in & ~alt_inp_in) | alt_drv_in);
        value    = (alt_drv_in & alt_val_in) | (~alt_drv_in & data_in);
        out_nxt  = value & ~od_in;
        oe_n_nxt = ~(drive & ~(od_in & value));
    end

    // pad output registers and two-stage pin synchroniser
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            out_r  <= '0;
            oe_n_r <= '1;
            s1_r   <= '0;
            s2_r   <= '0;
        end else begin
            out_r  <= out_nxt;
            oe_n_r <= oe_n_nxt;
            s1_r   <= pin_raw_in;
            s2_r   <= s1_r;
        end
    end

    assign pin_out      = out_r;
    assign pin_oe_n_out = oe_n_r;
    assign pin_sync_out = s2_r & impl;

    // open-drain pins never drive a high level
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    a_od_never_high: assert property (
        ##1 (pin_out & ~pin_oe_n_out & $past(od_in)) == {W{1'b0}})
        else $error("open-drain pin drives high");
endmodule : lpgc_pad
`default_nettype wire

// ---- design/lpgc_top.sv ----
// Overview of operation
// - four-bit port a data at c0
// - port a direction at c1, one outputs
// - one-bit port b data c2, direction c3
// - six-bit port c data c4, direction c5
// - port a pull-up enables at a5
// - port b pull-up enable at a6
// - port c pull-up enables at a7
// - port a alternate select clears on reset
// - select bit one hands pin to peripheral
// - pins seven and six feed external interrupts
// - pin four buzzer, pin one timer event
// - port b pin selectable as pwm wave
// - reduced variant drops port c pins four, five
// - reset clears every direction bit
// - open-drain select per pin, one open drain
// - read returns latch or live pin level
`timescale 1ns/1ps
`default_nettype none
module lpgc_top #(
    parameter bit REDUCED_PINS = 1'b0
) (
    input  wire logic       CLK_SYS_IN,
    input  wire logic       RESET_IN,
    input  wire logic [7:0] SFR_ADDR_IN,
    input  wire logic       SFR_WR_IN,
    input  wire logic [7:0] SFR_WDATA_IN,
    input  wire logic       SFR_RD_IN,
    input  wire logic       SFR_RD_PIN_IN,
    output logic      [7:0] SFR_RDATA_OUT,
    input  wire logic [7:0] PORT_A_PIN_IN,
    output logic      [7:0] PORT_A_PIN_OUT,
    output logic      [7:0] PORT_A_PIN_OE_N_OUT,
    output logic      [7:0] PORT_A_PULLUP_OUT,
    input  wire logic       PORT_B_PIN_IN,
    output logic            PORT_B_PIN_OUT,
    output logic            PORT_B_PIN_OE_N_OUT,
    output logic            PORT_B_PULLUP_OUT,
    input  wire logic [5:0] PORT_C_PIN_IN,
    output logic      [5:0] PORT_C_PIN_OUT,
    output logic      [5:0] PORT_C_PIN_OE_N_OUT,
    output logic      [5:0] PORT_C_PULLUP_OUT,
    input  wire logic       BUZZER_IN,
    input  wire logic       PWM_B_OR_TIMER_C_WAVE_IN,
    output logic            EXT_IRQ_A_OUT,
    output logic            EXT_IRQ_B_OUT,
    output logic            TIMER_A_EVENT_IN_OUT
);
    localparam logic [7:0] PC_MASK = REDUCED_PINS ?
        lpgc_pkg::PORT_C_SMALL_MASK : lpgc_pkg::PORT_C_MASK;
    // port a, b and c register file
    logic [7:0] port_a_r,           port_a_nxt;
    logic [7:0] port_a_dir_r,       port_a_dir_nxt;
    logic [7:0] port_a_pullup_r,    port_a_pullup_nxt;
    logic [7:0] port_a_opendrain_r, port_a_opendrain_nxt;
    logic [7:0] port_a_altsel_r,    port_a_altsel_nxt;
    logic       port_b_r,           port_b_nxt;
    logic       port_b_dir_r,       port_b_dir_nxt;
    logic       port_b_pullup_r,    port_b_pullup_nxt;
    logic       port_b_opendrain_r, port_b_opendrain_nxt;
    logic       port_b_altsel_r,    port_b_altsel_nxt;
    logic [5:0] port_c_r,           port_c_nxt;
    logic [5:0] port_c_dir_r,       port_c_dir_nxt;
    logic [5:0] port_c_pullup_r,    port_c_pullup_nxt;
    logic [5:0] port_c_opendrain_r, port_c_opendrain_nxt;
    // read data and peripheral-facing outputs
    logic [7:0] rdata_r,            rdata_nxt;
    logic       irq_a_r,            irq_a_nxt;
    logic       irq_b_r,            irq_b_nxt;
    logic       event_r,            event_nxt;
    // synchronised pin levels and alt routing
    logic [7:0] port_a_sync;
    logic       port_b_sync;
    logic [5:0] port_c_sync;
    logic [7:0] pa_alt_drv, pa_alt_val, pa_alt_inp;
    // byte-wide write test against a register offset
    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = SFR_WR_IN && (SFR_ADDR_IN == ofs);
    endfunction : wr_hit
    // pick latch or pin level for a data register read
    function automatic logic [7:0] rd_sel(input logic [7:0] latch,
                                          input logic [7:0] pin,
                                          input logic [7:0] mask);
        rd_sel = (SFR_RD_PIN_IN ? pin : latch) & mask;
    endfunction : rd_sel
    // next values of the register file on byte writes
    always_comb begin
        port_a_nxt           = port_a_r;
        port_a_dir_nxt       = port_a_dir_r;
        port_a_pullup_nxt    = port_a_pullup_r;
        port_a_opendrain_nxt = port_a_opendrain_r;
        port_a_altsel_nxt    = port_a_altsel_r;
        port_b_nxt           = port_b_r;
        port_b_dir_nxt       = port_b_dir_r;
        port_b_pullup_nxt    = port_b_pullup_r;
        port_b_opendrain_nxt = port_b_opendrain_r;
        port_b_altsel_nxt    = port_b_altsel_r;
        port_c_nxt           = port_c_r;
        port_c_dir_nxt       = port_c_dir_r;
        port_c_pullup_nxt    = port_c_pullup_r;
        port_c_opendrain_nxt = port_c_opendrain_r;
        if (wr_hit(lpgc_pkg::OFS_PORT_A)) begin
            port_a_nxt = SFR_WDATA_IN & lpgc_pkg::PORT_A_MASK;
        end
        if (wr_hit(lpgc_pkg::OFS_PORT_A_DIR)) begin
            port_a_dir_nxt = SFR_WDATA_IN & lpgc_pkg::PORT_A_MASK;
        end
        if (wr_hit(lpgc_pkg::OFS_PORT_A_PULLUP)) begin
            port_a_pullup_nxt = SFR_WDATA_IN & lpgc_pkg::PORT_A_MASK;
        end
        if (wr_hit(lpgc_pkg::OFS_PORT_A_OPENDRAIN)) begin
            port_a_opendrain_nxt = SFR_WDATA_IN & lpgc_pkg::PORT_A_MASK;
        end
        if (wr_hit(lpgc_pkg::OFS_PORT_A_ALTSEL)) begin
            port_a_altsel_nxt = SFR_WDATA_IN
                              & lpgc_pkg::PORT_A_ALTSEL_MASK;
        end
        if (wr_hit(lpgc_pkg::OFS_PORT_B)) begin
            port_b_nxt = SFR_WDATA_IN[0];
        end
        if (wr_hit(lpgc_pkg::OFS_PORT_B_DIR)) begin
            port_b_dir_nxt = SFR_WDATA_IN[0];
        end
        if (wr_hit(lpgc_pkg::OFS_PORT_B_PULLUP)) begin
            port_b_pullup_nxt = SFR_WDATA_IN[0];
        end
        if (wr_hit(lpgc_pkg::OFS_PORT_B_OPENDRAIN)) begin
            port_b_opendrain_nxt = SFR_WDATA_IN[0];
        end
        if (wr_hit(lpgc_pkg::OFS_PORT_B_ALTSEL)) begin
            port_b_altsel_nxt = SFR_WDATA_IN[lpgc_pkg::ALT_PWM_B_BIT];
        end
        if (wr_hit(lpgc_pkg::OFS_PORT_C)) begin
            port_c_nxt = SFR_WDATA_IN[5:0] & PC_MASK[5:0];
        end
        if (wr_hit(lpgc_pkg::OFS_PORT_C_DIR)) begin
            port_c_dir_nxt = SFR_WDATA_IN[5:0] & PC_MASK[5:0];
        end
        if (wr_hit(lpgc_pkg::OFS_PORT_C_PULLUP)) begin
            port_c_pullup_nxt = SFR_WDATA_IN[5:0] & PC_MASK[5:0];
        end
        if (wr_hit(lpgc_pkg::OFS_PORT_C_OPENDRAIN)) begin
            port_c_opendrain_nxt = SFR_WDATA_IN[5:0] & PC_MASK[5:0];
        end
    end
    // register file storage, all cleared by reset
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            port_a_r           <= lpgc_pkg::RST_VALUE;
            port_a_dir_r       <= lpgc_pkg::RST_VALUE;
            port_a_pullup_r    <= lpgc_pkg::RST_VALUE;
            port_a_opendrain_r <= lpgc_pkg::RST_VALUE;
            port_a_altsel_r    <= lpgc_pkg::RST_VALUE;
            port_b_r           <= lpgc_pkg::RST_VALUE[0];
            port_b_dir_r       <= lpgc_pkg::RST_VALUE[0];
            port_b_pullup_r    <= lpgc_pkg::RST_VALUE[0];
            port_b_opendrain_r <= lpgc_pkg::RST_VALUE[0];
            port_b_altsel_r    <= lpgc_pkg::RST_VALUE[0];
            port_c_r           <= lpgc_pkg::RST_VALUE[5:0];
            port_c_dir_r       <= lpgc_pkg::RST_VALUE[5:0];
            port_c_pullup_r    <= lpgc_pkg::RST_VALUE[5:0];
            port_c_opendrain_r <= lpgc_pkg::RST_VALUE[5:0];
        end else begin
            port_a_r           <= port_a_nxt;
            port_a_dir_r       <= port_a_dir_nxt;
            port_a_pullup_r    <= port_a_pullup_nxt;
            port_a_opendrain_r <= port_a_opendrain_nxt;
            port_a_altsel_r    <= port_a_altsel_nxt;
            port_b_r           <= port_b_nxt;
            port_b_dir_r       <= port_b_dir_nxt;
            port_b_pullup_r    <= port_b_pullup_nxt;
            port_b_opendrain_r <= port_b_opendrain_nxt;
            port_b_altsel_r    <= port_b_altsel_nxt;
            port_c_r           <= port_c_nxt;
            port_c_dir_r       <= port_c_dir_nxt;
            port_c_pullup_r    <= port_c_pullup_nxt;
            port_c_opendrain_r <= port_c_opendrain_nxt;
        end
    end
    // read mux: only data registers answer, control registers read zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (SFR_RD_IN) begin
            unique case (SFR_ADDR_IN)
                lpgc_pkg::OFS_PORT_A: rdata_nxt = rd_sel(port_a_r,
                    port_a_sync, lpgc_pkg::PORT_A_MASK);
                lpgc_pkg::OFS_PORT_B: rdata_nxt = rd_sel({7'h00, port_b_r},
                    {7'h00, port_b_sync}, lpgc_pkg::PORT_B_MASK);
                lpgc_pkg::OFS_PORT_C: rdata_nxt = rd_sel({2'h0, port_c_r},
                    {2'h0, port_c_sync}, PC_MASK);
                default: rdata_nxt = 8'h00;
            endcase
        end
    end
    // alternate function routing for port a and peripheral inputs
    always_comb begin
        pa_alt_drv = 8'h00;
        pa_alt_val = 8'h00;
        pa_alt_inp = 8'h00;
        pa_alt_drv[lpgc_pkg::ALT_BUZZER_BIT] =
            port_a_altsel_r[lpgc_pkg::ALT_BUZZER_BIT];
        pa_alt_val[lpgc_pkg::ALT_BUZZER_BIT] = BUZZER_IN;
        pa_alt_inp[lpgc_pkg::ALT_IRQ_B_BIT] =
            port_a_altsel_r[lpgc_pkg::ALT_IRQ_B_BIT];
        pa_alt_inp[lpgc_pkg::ALT_IRQ_A_BIT] =
            port_a_altsel_r[lpgc_pkg::ALT_IRQ_A_BIT];
        pa_alt_inp[lpgc_pkg::ALT_EVENT_BIT] =
            port_a_altsel_r[lpgc_pkg::ALT_EVENT_BIT];
        irq_a_nxt = port_a_altsel_r[lpgc_pkg::ALT_IRQ_A_BIT]
                  & port_a_sync[lpgc_pkg::ALT_IRQ_A_BIT];
        irq_b_nxt = port_a_altsel_r[lpgc_pkg::ALT_IRQ_B_BIT]
                  & port_a_sync[lpgc_pkg::ALT_IRQ_B_BIT];
        event_nxt = port_a_altsel_r[lpgc_pkg::ALT_EVENT_BIT]
                  & port_a_sync[lpgc_pkg::ALT_EVENT_BIT];
    end
    // read data and peripheral output registers
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            rdata_r <= 8'h00;
            irq_a_r <= 1'b0;
            irq_b_r <= 1'b0;
            event_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            irq_a_r <= irq_a_nxt;
            irq_b_r <= irq_b_nxt;
            event_r <= event_nxt;
        end
    end
    // pad logic for each port
    lpgc_pad #(.W(8), .IMPL(lpgc_pkg::PORT_A_MASK)) u_pad_a (
        .clk_in       (CLK_SYS_IN),
        .reset_in     (RESET_IN),
        .data_in      (port_a_r),
        .dir_in       (port_a_dir_r),
        .od_in        (port_a_opendrain_r),
        .alt_drv_in   (pa_alt_drv),
        .alt_val_in   (pa_alt_val),
        .alt_inp_in   (pa_alt_inp),
        .pin_raw_in   (PORT_A_PIN_IN),
        .pin_out      (PORT_A_PIN_OUT),
        .pin_oe_n_out (PORT_A_PIN_OE_N_OUT),
        .pin_sync_out (port_a_sync)
    );
    lpgc_pad #(.W(1), .IMPL(lpgc_pkg::PORT_B_MASK)) u_pad_b (
        .clk_in       (CLK_SYS_IN),
        .reset_in     (RESET_IN),
        .data_in      (port_b_r),
        .dir_in       (port_b_dir_r),
        .od_in        (port_b_opendrain_r),
        .alt_drv_in   (port_b_altsel_r),
        .alt_val_in   (PWM_B_OR_TIMER_C_WAVE_IN),
        .alt_inp_in   (1'b0),
        .pin_raw_in   (PORT_B_PIN_IN),
        .pin_out      (PORT_B_PIN_OUT),
        .pin_oe_n_out (PORT_B_PIN_OE_N_OUT),
        .pin_sync_out (port_b_sync)
    );
    lpgc_pad #(.W(6), .IMPL(PC_MASK)) u_pad_c (
        .clk_in       (CLK_SYS_IN),
        .reset_in     (RESET_IN),
        .data_in      (port_c_r),
        .dir_in       (port_c_dir_r),
        .od_in        (port_c_opendrain_r),
        .alt_drv_in   (6'h00),
        .alt_val_in   (6'h00),
        .alt_inp_in   (6'h00),
        .pin_raw_in   (PORT_C_PIN_IN),
        .pin_out      (PORT_C_PIN_OUT),
        .pin_oe_n_out (PORT_C_PIN_OE_N_OUT),
        .pin_sync_out (port_c_sync)
    );
    // pull-up enables straight from the select registers
    assign PORT_A_PULLUP_OUT    = port_a_pullup_r;
    assign PORT_B_PULLUP_OUT    = port_b_pullup_r;
    assign PORT_C_PULLUP_OUT    = port_c_pullup_r;
    assign SFR_RDATA_OUT        = rdata_r;
    assign EXT_IRQ_A_OUT        = irq_a_r;
    assign EXT_IRQ_B_OUT        = irq_b_r;
    assign TIMER_A_EVENT_IN_OUT = event_r;
    // checks
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RESET_IN);
    sequence s_wr_dir_a;
        SFR_WR_IN && SFR_ADDR_IN == lpgc_pkg::OFS_PORT_A_DIR;
    endsequence
    sequence s_rd_ctrl;
        SFR_RD_IN && (SFR_ADDR_IN == lpgc_pkg::OFS_PORT_A_DIR ||
                      SFR_ADDR_IN == lpgc_pkg::OFS_PORT_A_ALTSEL);
    endsequence
    sequence s_rd_pin_a;
        SFR_RD_IN && SFR_RD_PIN_IN && SFR_ADDR_IN == lpgc_pkg::OFS_PORT_A;
    endsequence
    a_dir_write_lands: assert property (
        s_wr_dir_a |=> port_a_dir_r ==
            ($past(SFR_WDATA_IN) & lpgc_pkg::PORT_A_MASK))
        else $error("port a direction write not stored");
    a_reset_all_inputs: assert property (disable iff (1'b0)
        RESET_IN |=> port_a_dir_r == 8'h00 && !port_b_dir_r
            && port_c_dir_r == 6'h00)
        else $error("direction not cleared by reset");
    a_altsel_reset_clear: assert property (disable iff (1'b0)
        RESET_IN |=> port_a_altsel_r == 8'h00 && !port_b_altsel_r)
        else $error("alternate select not cleared by reset");
    a_ctrl_read_zero: assert property (
        s_rd_ctrl |=> SFR_RDATA_OUT == 8'h00)
        else $error("write-only register read not zero");
    a_pin_read_level: assert property (
        s_rd_pin_a |=> SFR_RDATA_OUT ==
            ($past(port_a_sync) & lpgc_pkg::PORT_A_MASK))
        else $error("pin read does not return pin level");
    a_irq_b_route: assert property (
        port_a_altsel_r[7] && port_a_sync[7] |=> EXT_IRQ_B_OUT)
        else $error("pin seven not routed to interrupt b");
    a_irq_off_gpio: assert property (
        !port_a_altsel_r[6] |=> !EXT_IRQ_A_OUT)
        else $error("interrupt a active while pin is gpio");
    a_buzzer_drive: assert property (
        port_a_altsel_r[4] && !port_a_opendrain_r[4] |=>
            !PORT_A_PIN_OE_N_OUT[4] && PORT_A_PIN_OUT[4] == $past(BUZZER_IN))
        else $error("buzzer not driven on pin four");
    a_pwm_drive: assert property (
        port_b_altsel_r && !port_b_opendrain_r |=> !PORT_B_PIN_OE_N_OUT
            && PORT_B_PIN_OUT == $past(PWM_B_OR_TIMER_C_WAVE_IN))
        else $error("pwm wave not driven on port b");
    a_reduced_pins_off: assert property (
        REDUCED_PINS |-> PORT_C_PIN_OE_N_OUT[5:4] == 2'b11
            && port_c_dir_r[5:4] == 2'b00)
        else $error("omitted port c pins driven");
    a_gpio_from_latch: assert property (
        port_a_dir_r[1] && !port_a_altsel_r[1] && !port_a_opendrain_r[1]
        |=> !PORT_A_PIN_OE_N_OUT[1] && PORT_A_PIN_OUT[1] == $past(port_a_r[1]))
        else $error("gpio output not driven from latch");
endmodule : lpgc_top
`default_nettype wire

// ---- verif/lpgc_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpgc_cpu_model (
    input  wire logic       clk_in,
    output var  logic [7:0] addr_out,
    output var  logic       wr_out,
    output var  logic [7:0] wdata_out,
    output var  logic       rd_out,
    output var  logic       rd_pin_out,
    input  wire logic [7:0] rdata_in
);
    // bus idle at time zero
    initial begin
        addr_out   = 8'h00;
        wr_out     = 1'b0;
        wdata_out  = 8'h00;
        rd_out     = 1'b0;
        rd_pin_out = 1'b0;
    end
    // whole-byte write, strobe high for one sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge clk_in);
        wr_out    <= 1'b0;
        wdata_out <= ~d; // no stale data once strobe is gone
    endtask : wr
    // byte read of latch or pin level, data taken one edge later
    task automatic rd(input logic [7:0] a, input logic pin,
                      output logic [7:0] d);
        @(posedge clk_in);
        addr_out   <= a;
        rd_pin_out <= pin;
        rd_out     <= 1'b1;
        @(posedge clk_in);
        rd_out     <= 1'b0;
        @(posedge clk_in);
        d = rdata_in;
    endtask : rd
endmodule : lpgc_cpu_model
`default_nettype wire

// ---- verif/low_ports_gpio_config_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module low_ports_gpio_config_tb;
    logic       clk, rst, pb_in, buz, pwm, wr, rd, rdp;
    logic [7:0] pa_in, addr, wdata, rdata, pa_out, pa_oe, pa_pu, got;
    logic [5:0] pc_in, pc_out, pc_oe, pc_pu, pcr_out, pcr_oe, pcr_pu;
    logic       pb_out, pb_oe, pb_pu, irq_a, irq_b, ev;
    int         fails, total_checks, cycles;
    logic [31:0] seed;
    logic [7:0] m [0:255];
    logic [7:0] tbl [0:15] = '{8'ha0, 8'ha1, 8'ha2, 8'ha5, 8'ha6, 8'ha7,
        8'haa, 8'hab, 8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'ha3, 8'h50};
    logic [15:0] dir_t [0:9] = '{16'hc1ff, 16'hc0ff, 16'haad2, 16'ha0ff,
        16'hc301, 16'hab01, 16'ha101, 16'hc53f, 16'hc43f, 16'ha7ff};

    lpgc_cpu_model cpu (.clk_in(clk), .addr_out(addr), .wr_out(wr),
        .wdata_out(wdata), .rd_out(rd), .rd_pin_out(rdp), .rdata_in(rdata));
    lpgc_top dut (.CLK_SYS_IN(clk), .RESET_IN(rst), .SFR_ADDR_IN(addr),
        .SFR_WR_IN(wr), .SFR_WDATA_IN(wdata), .SFR_RD_IN(rd),
        .SFR_RD_PIN_IN(rdp), .SFR_RDATA_OUT(rdata), .PORT_A_PIN_IN(pa_in),
        .PORT_A_PIN_OUT(pa_out), .PORT_A_PIN_OE_N_OUT(pa_oe),
        .PORT_A_PULLUP_OUT(pa_pu), .PORT_B_PIN_IN(pb_in),
        .PORT_B_PIN_OUT(pb_out), .PORT_B_PIN_OE_N_OUT(pb_oe),
        .PORT_B_PULLUP_OUT(pb_pu), .PORT_C_PIN_IN(pc_in),
        .PORT_C_PIN_OUT(pc_out), .PORT_C_PIN_OE_N_OUT(pc_oe),
        .PORT_C_PULLUP_OUT(pc_pu), .BUZZER_IN(buz),
        .PWM_B_OR_TIMER_C_WAVE_IN(pwm), .EXT_IRQ_A_OUT(irq_a),
        .EXT_IRQ_B_OUT(irq_b), .TIMER_A_EVENT_IN_OUT(ev));
    // reduced-pin variant on the same bus and pins
    lpgc_top #(.REDUCED_PINS(1'b1)) dut_small (.CLK_SYS_IN(clk),
        .RESET_IN(rst), .SFR_ADDR_IN(addr), .SFR_WR_IN(wr),
        .SFR_WDATA_IN(wdata), .SFR_RD_IN(rd), .SFR_RD_PIN_IN(rdp),
        .SFR_RDATA_OUT(), .PORT_A_PIN_IN(pa_in), .PORT_A_PIN_OUT(),
        .PORT_A_PIN_OE_N_OUT(), .PORT_A_PULLUP_OUT(),
        .PORT_B_PIN_IN(pb_in), .PORT_B_PIN_OUT(), .PORT_B_PIN_OE_N_OUT(),
        .PORT_B_PULLUP_OUT(), .PORT_C_PIN_IN(pc_in),
        .PORT_C_PIN_OUT(pcr_out), .PORT_C_PIN_OE_N_OUT(pcr_oe),
        .PORT_C_PULLUP_OUT(pcr_pu), .BUZZER_IN(buz),
        .PWM_B_OR_TIMER_C_WAVE_IN(pwm), .EXT_IRQ_A_OUT(), .EXT_IRQ_B_OUT(),
        .TIMER_A_EVENT_IN_OUT());

    // pseudo-random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // bits that each register keeps
    function automatic logic [7:0] wm(input logic [7:0] a);
        case (a)
            8'ha0, 8'ha5, 8'haa, 8'hc0, 8'hc1: return 8'hd2;
            8'ha1, 8'ha6, 8'hab, 8'hc2, 8'hc3: return 8'h01;
            8'ha2, 8'ha7, 8'hc4, 8'hc5:        return 8'h3f;
            default:                           return 8'h00;
        endcase
    endfunction : wm
    // data ports read latch or pin, all else reads zero
    function automatic logic [7:0] exp_rd(input logic [7:0] a,
                                          input logic p);
        case (a)
            8'hc0:   return p ? (pa_in & 8'hd2) : m[a];
            8'hc2:   return p ? {7'h00, pb_in} : m[a];
            8'hc4:   return p ? {2'b00, pc_in} : m[a];
            default: return 8'h00;
        endcase
    endfunction : exp_rd
    task automatic chk(input string n, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // expected drive of one port from its register model
    task automatic port(input string n, input logic [7:0] dat, dir, od,
                        msk, ao, ai, av, oe, out);
        logic [7:0] en, v, eoe;
        en  = ((dir & ~ai) | ao) & msk;
        v   = (ao & av) | (~ao & dat);
        eoe = ~(en & ~(od & v));
        chk({n, " oe_n"}, eoe, oe);
        chk({n, " out"}, v & ~eoe, out & ~eoe);
    endtask : port
    task automatic check_all;
        port("a", m[8'hc0], m[8'hc1], m[8'ha0], 8'hd2, m[8'haa] & 8'h10,
             m[8'haa] & 8'hc2, {8{buz}}, pa_oe, pa_out);
        port("b", m[8'hc2], m[8'hc3], m[8'ha1], 8'h01, m[8'hab] & 8'h01,
             8'h00, {8{pwm}}, {7'h7f, pb_oe}, {7'h00, pb_out});
        port("c", m[8'hc4], m[8'hc5], m[8'ha2], 8'h3f, 8'h00, 8'h00,
             8'h00, {2'b11, pc_oe}, {2'b00, pc_out});
        port("c small", m[8'hc4], m[8'hc5], m[8'ha2], 8'h0f, 8'h00, 8'h00,
             8'h00, {2'b11, pcr_oe}, {2'b00, pcr_out});
        chk("pullup c small", m[8'ha7] & 8'h0f, {2'b00, pcr_pu});
        chk("pullup a", m[8'ha5], pa_pu);
        chk("pullup b", m[8'ha6], {7'h00, pb_pu});
        chk("pullup c", m[8'ha7], {2'b00, pc_pu});
        chk("irq a", {7'h00, m[8'haa][6] & pa_in[6]}, {7'h00, irq_a});
        chk("irq b", {7'h00, m[8'haa][7] & pa_in[7]}, {7'h00, irq_b});
        chk("event", {7'h00, m[8'haa][1] & pa_in[1]}, {7'h00, ev});
        cpu.rd(8'hc0, 1'b1, got);
        chk("pin read a", exp_rd(8'hc0, 1'b1), got);
    endtask : check_all
    task automatic results;
        if (fails == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            results();
        end
    end
    // main sequence
    initial begin
        logic [7:0] a;
        rst   = 1'b1;
        pa_in = 8'h00;
        pb_in = 1'b0;
        pc_in = 6'h00;
        buz   = 1'b0;
        pwm   = 1'b0;
        seed  = 32'hafc5;
        for (int i = 0; i < 256; i++) m[i] = 8'h00;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check_all();
        for (int i = 0; i < 10; i++) begin
            cpu.wr(dir_t[i][15:8], dir_t[i][7:0]);
            m[dir_t[i][15:8]] = dir_t[i][7:0] & wm(dir_t[i][15:8]);
            repeat (4) @(posedge clk);
            check_all();
        end
        for (int i = 0; i < 48; i++) begin
            seed = lfsr(seed);
            @(posedge clk);
            pa_in <= seed[7:0];
            pb_in <= seed[8];
            pc_in <= seed[14:9];
            buz   <= seed[15];
            pwm   <= seed[16];
            a = tbl[seed[20:17]];
            cpu.wr(a, seed[31:24]);
            m[a] = seed[31:24] & wm(a);
            repeat (4) @(posedge clk);
            check_all();
            cpu.rd(a, seed[21], got);
            chk("read back", exp_rd(a, seed[21]), got);
        end
        results();
    end
endmodule : low_ports_gpio_config_tb
`default_nettype wire
